/* hw/sswd_supervisor.sv */
// Contract
// - resets low until rail good plus delay
// - delay default 64 ms, settable 8/16/32
// - cold start restores default settings
// - warm start keeps last written settings
// - main rail retention low sets flag one
// - second rail retention low sets flag two
// - both flags clear after completed transfer
// - error pin low on fault, cause reported
// - trigger only on a full word, main reset released, bit one
// - trigger taken at select rising edge
// - pattern 010 alone disables the watchdog
// - each tracker follows its enable bit
// - tracker shorts reported per tracker
// - tracker open load reported per tracker
// - fail: error at once, reset after half window
// - early trigger or missing trigger fails
// - new control word adopted at select high
// - delay field 00/01/10/11 is 64/32/16/8
`timescale 1ns/1ns
`default_nettype none
module sswd_supervisor #(
   parameter int unsigned RES_UNIT_CYC = sswd_pkg::RES_UNIT_CYC,
   parameter int unsigned WD_UNIT_CYC = sswd_pkg::WD_UNIT_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic spiClk,
   input wire logic spiCsN,
   input wire logic spiDi,
   input wire logic [2:0] railGood,
   input wire logic mainBelowRetain,
   input wire logic secondBelowRetain,
   input wire logic coldStart,
   input wire logic overTemp,
   input wire logic [5:0] trackerShort,
   input wire logic [5:0] trackerOpen,
   output logic spiDoOut,
   output logic spiDoOe,
   output logic mainRailResetOut,
   output logic mainRailResetOe,
   output logic secondRailResetOut,
   output logic secondRailResetOe,
   output logic thirdRailResetOut,
   output logic thirdRailResetOe,
   output logic errN,
   output logic [5:0] sensorTrackerEn,
   output logic normalMode
);
   sswd_pkg::sswd_pins_s pinsRaw;
   sswd_pkg::sswd_pins_s pins;
   logic [$bits(sswd_pkg::sswd_pins_s)-1:0] pinsQ;

   assign pinsRaw = {spiClk, spiCsN, spiDi, railGood, mainBelowRetain,
      secondBelowRetain, coldStart, overTemp, trackerShort, trackerOpen};

   sswd_sync3 #(
      .WIDTH($bits(sswd_pkg::sswd_pins_s)),
      .RST_VAL(sswd_pkg::PINS_IDLE)
   ) uSync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d(pinsRaw),
      .q(pinsQ)
   );
   assign pins = pinsQ;

   // Serial port
   logic sckPrev_r, sckPrev_nxt, csPrev_r, csPrev_nxt, diBit_r, diBit_nxt;
   logic [15:0] sh_r, sh_nxt;
   logic [4:0] bitCnt_r, bitCnt_nxt;
   logic doOut_r, doOut_nxt, doOe_r, doOe_nxt;
   logic sckRise, sckFall, csFall, csRise, frameEnd, frameDone, trig;
   sswd_pkg::sswd_status_s status;
   logic [2:0] rstOut_r;
   logic wdErr_r, ram1_r, ram2_r;

   assign sckRise = pins.spiClk & ~sckPrev_r;
   assign sckFall = ~pins.spiClk & sckPrev_r;
   assign csFall = ~pins.spiCsN & csPrev_r;
   assign csRise = pins.spiCsN & ~csPrev_r;
   assign frameEnd = csRise && (bitCnt_r == sswd_pkg::WORD_BITS_CNT);
   // No command is taken while the main reset is still held
   assign frameDone = frameEnd & rstOut_r[0];
   assign trig = frameDone & sh_r[sswd_pkg::BIT_TRIG];

   always_comb
   begin
      status.anyErr = ~errN;
      status.wdFail = wdErr_r;
      status.ramGood1 = ram1_r;
      status.ramGood2 = ram2_r;
      status.trkShort = pins.trkShort;
      status.trkOpen = pins.trkOpen;
   end

   always_comb
   begin
      sckPrev_nxt = pins.spiClk;
      csPrev_nxt = pins.spiCsN;
      diBit_nxt = diBit_r;
      sh_nxt = sh_r;
      bitCnt_nxt = bitCnt_r;
      doOut_nxt = doOut_r;
      doOe_nxt = pins.spiCsN;
      if (csFall)
      begin
         sh_nxt = status;
         bitCnt_nxt = '0;
         doOut_nxt = status[15];
      end
      else if (!pins.spiCsN)
      begin
         if (sckRise)
         begin
            diBit_nxt = pins.spiDi;
         end
         if (sckFall)
         begin
            // Status leaves and command enters the same register
            sh_nxt = {sh_r[14:0], diBit_r};
            doOut_nxt = sh_r[14];
            if (bitCnt_r != sswd_pkg::WORD_BITS_CNT)
            begin
               bitCnt_nxt = bitCnt_r + 5'h1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sckPrev_r <= 1'b0;
         csPrev_r <= 1'b1;
         diBit_r <= 1'b0;
         sh_r <= '0;
         bitCnt_r <= '0;
         doOut_r <= 1'b0;
         doOe_r <= 1'b1;
      end
      else
      begin
         sckPrev_r <= sckPrev_nxt;
         csPrev_r <= csPrev_nxt;
         diBit_r <= diBit_nxt;
         sh_r <= sh_nxt;
         bitCnt_r <= bitCnt_nxt;
         doOut_r <= doOut_nxt;
         doOe_r <= doOe_nxt;
      end
   end

   // Control word, retention copy and flags
   logic [15:0] ctrl_r, ctrl_nxt, shadow_r, shadow_nxt;
   logic [2:0] settle_r, settle_nxt;
   logic loadNow, loadDone, ram1_nxt, ram2_nxt;
   logic [5:0] trkEn_r, trkEn_nxt;
   logic normal_r, normal_nxt;

   assign loadDone = (settle_r == sswd_pkg::SETTLE_CYC);
   assign loadNow = (settle_r == sswd_pkg::SETTLE_CYC - 3'h1);

   always_comb
   begin
      settle_nxt = loadDone ? settle_r : settle_r + 3'h1;
      ctrl_nxt = ctrl_r;
      shadow_nxt = shadow_r;
      if (loadNow && !pins.coldStart)
      begin
         ctrl_nxt = shadow_r;
      end
      if (frameDone)
      begin
         ctrl_nxt = sh_r;
         shadow_nxt = sh_r;
      end
      // Set wins over the clear at the end of a transfer
      ram1_nxt = (ram1_r & ~frameEnd) | pins.mainLow
         | (loadNow & pins.coldStart);
      ram2_nxt = (ram2_r & ~frameEnd) | pins.secondLow;
      trkEn_nxt = ctrl_r[sswd_pkg::TRK_MSB:sswd_pkg::TRK_LSB];
      normal_nxt = ctrl_r[sswd_pkg::BIT_NORMAL];
   end

   // Retention copy rides through the main reset; it lives on standby
   always_ff @(posedge sys_clk)
   begin
      shadow_r <= shadow_nxt;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         settle_r <= '0;
         ctrl_r <= sswd_pkg::CTRL_DEFAULT;
         ram1_r <= 1'b0;
         ram2_r <= 1'b0;
         trkEn_r <= '0;
         normal_r <= 1'b1;
      end
      else
      begin
         settle_r <= settle_nxt;
         ctrl_r <= ctrl_nxt;
         ram1_r <= ram1_nxt;
         ram2_r <= ram2_nxt;
         trkEn_r <= trkEn_nxt;
         normal_r <= normal_nxt;
      end
   end

   // Reset outputs, one delay counter per rail
   logic [1:0] resShift, wdShift;
   logic [31:0] resDelay, winCyc;
   logic wdRst_r;
   logic [31:0] rstCnt_r [3];

   assign resShift = sswd_pkg::MAX_SHIFT
      - {ctrl_r[sswd_pkg::BIT_RES_B], ctrl_r[sswd_pkg::BIT_RES_A]};
   assign resDelay = 32'(RES_UNIT_CYC) << resShift;
   assign wdShift = sswd_pkg::MAX_SHIFT
      - {ctrl_r[sswd_pkg::BIT_WD_B], ctrl_r[sswd_pkg::BIT_WD_A]};
   assign winCyc = 32'(WD_UNIT_CYC) << wdShift;

   for (genvar g = 0; g < 3; g++)
   begin : gRail
      logic hold;
      logic [31:0] cnt_nxt;
      logic out_nxt;
      always_comb
      begin
         hold = ~pins.railGood[g] | ~loadDone | ((g == 0) & wdRst_r);
         cnt_nxt = rstCnt_r[g];
         if (hold)
         begin
            cnt_nxt = '0;
         end
         else if (rstCnt_r[g] < resDelay)
         begin
            cnt_nxt = rstCnt_r[g] + 32'h1;
         end
         out_nxt = ~hold && (rstCnt_r[g] >= resDelay);
      end
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            rstCnt_r[g] <= '0;
            rstOut_r[g] <= 1'b0;
         end
         else
         begin
            rstCnt_r[g] <= cnt_nxt;
            rstOut_r[g] <= out_nxt;
         end
      end
   end

   // Window watchdog
   sswd_pkg::sswd_wd_e wdState_r, wdState_nxt;
   logic [31:0] wdCnt_r, wdCnt_nxt;
   logic wdErr_nxt, wdRst_nxt, errN_r, errN_nxt, wdOff;

   assign wdOff = ({ctrl_r[sswd_pkg::BIT_WDOFF1], ctrl_r[sswd_pkg::BIT_WDOFF2],
      ctrl_r[sswd_pkg::BIT_WDOFF3]} == sswd_pkg::WATCHDOG_DISABLE_BITS_PATTERN);

   always_comb
   begin
      wdState_nxt = wdState_r;
      wdCnt_nxt = wdCnt_r + 32'h1;
      wdErr_nxt = wdErr_r & ~frameEnd;
      wdRst_nxt = 1'b0;
      unique case (wdState_r)
         sswd_pkg::WD_IDLE:
         begin
            wdCnt_nxt = '0;
            if (rstOut_r[0] && !wdOff)
            begin
               wdState_nxt = sswd_pkg::WD_CLOSED;
            end
         end
         sswd_pkg::WD_CLOSED:
         begin
            if (wdOff || !rstOut_r[0])
            begin
               wdState_nxt = sswd_pkg::WD_IDLE;
            end
            else if (trig)
            begin
               wdState_nxt = sswd_pkg::WD_FAIL;
               wdCnt_nxt = '0;
               wdErr_nxt = 1'b1;
            end
            else if (wdCnt_r >= winCyc - 32'h1)
            begin
               wdState_nxt = sswd_pkg::WD_OPEN;
               wdCnt_nxt = '0;
            end
         end
         sswd_pkg::WD_OPEN:
         begin
            if (wdOff || !rstOut_r[0])
            begin
               wdState_nxt = sswd_pkg::WD_IDLE;
            end
            else if (trig)
            begin
               // A new window length takes effect from this window on
               wdState_nxt = sswd_pkg::WD_CLOSED;
               wdCnt_nxt = '0;
            end
            else if (wdCnt_r >= winCyc - 32'h1)
            begin
               wdState_nxt = sswd_pkg::WD_FAIL;
               wdCnt_nxt = '0;
               wdErr_nxt = 1'b1;
            end
         end
         sswd_pkg::WD_FAIL:
         begin
            if (wdCnt_r >= (winCyc >> 1) - 32'h1)
            begin
               wdRst_nxt = 1'b1;
               wdState_nxt = sswd_pkg::WD_IDLE;
            end
         end
      endcase
      errN_nxt = ~(wdErr_nxt | pins.overTemp | (|pins.trkShort));
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wdState_r <= sswd_pkg::WD_IDLE;
         wdCnt_r <= '0;
         wdErr_r <= 1'b0;
         wdRst_r <= 1'b0;
         errN_r <= 1'b1;
      end
      else
      begin
         wdState_r <= wdState_nxt;
         wdCnt_r <= wdCnt_nxt;
         wdErr_r <= wdErr_nxt;
         wdRst_r <= wdRst_nxt;
         errN_r <= errN_nxt;
      end
   end

   // Open-collector pins: enable low while pulling the line low
   assign mainRailResetOut = rstOut_r[0];
   assign mainRailResetOe = rstOut_r[0];
   assign secondRailResetOut = rstOut_r[1];
   assign secondRailResetOe = rstOut_r[1];
   assign thirdRailResetOut = rstOut_r[2];
   assign thirdRailResetOe = rstOut_r[2];
   assign spiDoOut = doOut_r;
   assign spiDoOe = doOe_r;
   assign errN = errN_r;
   assign sensorTrackerEn = trkEn_r;
   assign normalMode = normal_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   chk_ctrl_adopt: assert property (frameDone |=> ctrl_r == $past(sh_r))
      else $error("control word not adopted at select high");
   chk_cold_default: assert property (loadNow && pins.coldStart && !frameDone
      |=> ctrl_r == sswd_pkg::CTRL_DEFAULT)
      else $error("cold start did not restore defaults");
   chk_ram_set: assert property (pins.mainLow |=> ram1_r)
      else $error("retention flag one not set");
   chk_ram_clear: assert property (frameEnd && !pins.mainLow && !pins.secondLow
      && !loadNow |=> !ram1_r && !ram2_r)
      else $error("retention flags not cleared after transfer");
   chk_early_trig: assert property (wdState_r == sswd_pkg::WD_CLOSED && trig
      && rstOut_r[0] && !wdOff |=> wdState_r == sswd_pkg::WD_FAIL && !errN)
      else $error("trigger in closed window not failed");
   chk_fail_reset: assert property (wdRst_r |=> !mainRailResetOut[*2])
      else $error("main reset not asserted after watchdog fail");
   chk_watchdog_disable_bits: assert property (wdOff |=> wdState_r == sswd_pkg::WD_IDLE
      || $past(wdState_r) == sswd_pkg::WD_FAIL)
      else $error("watchdog active while disabled");
   chk_release_delay: assert property ($rose(rstOut_r[1])
      |-> rstCnt_r[1] >= $past(resDelay))
      else $error("second reset released before delay");
   chk_rail_hold: assert property (!pins.railGood[2] |=> !thirdRailResetOut)
      else $error("third reset released while rail low");
   cov_good_trigger: cover property (wdState_r == sswd_pkg::WD_OPEN && trig);
   cov_frame: cover property (frameDone);
   cov_wd_reset: cover property ($rose(wdRst_r));
endmodule : sswd_supervisor
`default_nettype wire

/* hw/sswd_pkg.sv */
package sswd_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
   // Shortest settings; the others are these doubled per field step
   localparam int unsigned RES_MIN_US = 8000;
   localparam int unsigned WD_MIN_US = 16000;
   localparam int unsigned RES_UNIT_CYC = RES_MIN_US * CYC_PER_US;
   localparam int unsigned WD_UNIT_CYC = WD_MIN_US * CYC_PER_US;
   localparam int unsigned WORD_BITS = 16;
   localparam logic [4:0] WORD_BITS_CNT = 5'h10;
   // Load waits one cycle past the pin synchroniser's latency
   localparam logic [2:0] SETTLE_CYC = 3'h5;
   localparam logic [15:0] CTRL_DEFAULT = 16'h4301;
   localparam int unsigned BIT_WDOFF1 = 0;
   localparam int unsigned TRK_LSB = 2;
   localparam int unsigned TRK_MSB = 7;
   localparam int unsigned BIT_NORMAL = 8;
   localparam int unsigned BIT_WDOFF2 = 9;
   localparam int unsigned BIT_RES_A = 10;
   localparam int unsigned BIT_RES_B = 11;
   localparam int unsigned BIT_WD_A = 12;
   localparam int unsigned BIT_WD_B = 13;
   localparam int unsigned BIT_WDOFF3 = 14;
   localparam int unsigned BIT_TRIG = 15;
   localparam logic [2:0] WATCHDOG_DISABLE_BITS_PATTERN = 3'h2;
   localparam logic [1:0] MAX_SHIFT = 2'h3;

   typedef enum logic [1:0]
   {
      WD_IDLE = 2'h0,
      WD_CLOSED = 2'h1,
      WD_OPEN = 2'h3,
      WD_FAIL = 2'h2
   } sswd_wd_e;

   typedef struct packed
   {
      logic anyErr;
      logic wdFail;
      logic ramGood1;
      logic ramGood2;
      logic [5:0] trkShort;
      logic [5:0] trkOpen;
   } sswd_status_s;

   typedef struct packed
   {
      logic spiClk;
      logic spiCsN;
      logic spiDi;
      logic [2:0] railGood;
      logic mainLow;
      logic secondLow;
      logic coldStart;
      logic overTemp;
      logic [5:0] trkShort;
      logic [5:0] trkOpen;
   } sswd_pins_s;

   // Pins as seen in reset: select idle high so no false frame start
   localparam sswd_pins_s PINS_IDLE = '{spiCsN: 1'b1, default: '0};
endpackage : sswd_pkg

/* hw/sswd_sync3.sv */
`timescale 1ns/1ns
`default_nettype none
module sswd_sync3 #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] q_r;
   logic [WIDTH-1:0] q_nxt;

   // A change is taken only once stages two and three agree
   always_comb
   begin
      q_nxt = q_r;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (s2_r[i] == s3_r[i])
         begin
            q_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         q_r <= RST_VAL;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule : sswd_sync3
`default_nettype wire

/* verification/sswd_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sswd_host_model (
   input wire logic sys_clk,
   input wire logic spiDoOut,
   input wire logic spiDoOe,
   output logic spiClk,
   output logic spiCsN,
   output logic spiDi
);
   // Off the clock grid so the block must find edges of a foreign phase
   localparam int PHASE_NS = 37;
   localparam int HALF_NS = 400;
   logic oeLost;

   initial
   begin
      spiClk = 1'b0;
      spiCsN = 1'b1;
      spiDi = 1'b0;
      oeLost = 1'b0;
   end

   // Sends the top nBits of w, MSB first; DO is taken just before SCK
   // falls, as the block moves DO a few clocks after each falling edge
   task automatic xfer(input logic [15:0] w, input int nBits,
      output logic [15:0] rd);
      int i;
      rd = 16'h0000;
      @(posedge sys_clk);
      #(PHASE_NS);
      spiCsN = 1'b0;
      #(2 * HALF_NS);
      for (i = 15; i > 15 - nBits; i--)
      begin
         spiDi = w[i];
         #(HALF_NS);
         spiClk = 1'b1;
         #(HALF_NS);
         // A released line reads as the opposite of the last bit
         rd = {rd[14:0], (spiDoOe === 1'b0) ? spiDoOut : ~spiDoOut};
         if (spiDoOe !== 1'b0)
            oeLost = 1'b1;
         spiClk = 1'b0;
      end
      #(HALF_NS);
      spiCsN = 1'b1;
      // A released line must not keep showing the last bit
      spiDi = ~spiDi;
      #(2 * HALF_NS);
   endtask : xfer
endmodule : sswd_host_model
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   // Short units keep the run brief; release delays scale from them, watchdog timings are literal counts
   localparam int RES_UNIT = 40;
   localparam int WD_UNIT = 80;
   localparam int SLACK = 16;
   logic sys_clk;
   logic rst_n;
   logic spiClk;
   logic spiCsN;
   logic spiDi;
   logic spiDoOut;
   logic spiDoOe;
   logic [2:0] railGood;
   logic mainBelowRetain;
   logic secondBelowRetain;
   logic coldStart;
   logic overTemp;
   logic [5:0] trackerShort;
   logic [5:0] trackerOpen;
   logic mainRailResetOut;
   logic secondRailResetOut;
   logic thirdRailResetOut;
   logic errN;
   logic [5:0] sensorTrackerEn;
   logic normalMode;
   logic [3:0] obs;
   logic [15:0] mCtrl;
   logic [15:0] expQ[$];
   logic [31:0] rnd;
   logic expB;
   int failures = 0;
   int nTests = 0;
   int seed = 32'h3BF8C6B8;
   int mF1;
   int mF2;
   int mWdFail;
   int i;
   int dly[4] = '{8 * RES_UNIT, 4 * RES_UNIT, 2 * RES_UNIT, RES_UNIT};

   sswd_supervisor #(.RES_UNIT_CYC(RES_UNIT), .WD_UNIT_CYC(WD_UNIT))
   sswd_supervisor_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .spiClk(spiClk), .spiCsN(spiCsN), .spiDi(spiDi), .railGood(railGood),
      .mainBelowRetain(mainBelowRetain), .secondBelowRetain(secondBelowRetain),
      .coldStart(coldStart), .overTemp(overTemp),
      .trackerShort(trackerShort), .trackerOpen(trackerOpen),
      .spiDoOut(spiDoOut), .spiDoOe(spiDoOe),
      .mainRailResetOut(mainRailResetOut), .mainRailResetOe(),
      .secondRailResetOut(secondRailResetOut), .secondRailResetOe(),
      .thirdRailResetOut(thirdRailResetOut), .thirdRailResetOe(),
      .errN(errN), .sensorTrackerEn(sensorTrackerEn),
      .normalMode(normalMode));

   sswd_host_model sswd_host_model_inst (.sys_clk(sys_clk),
      .spiDoOut(spiDoOut), .spiDoOe(spiDoOe), .spiClk(spiClk),
      .spiCsN(spiCsN), .spiDi(spiDi));

   assign obs = {errN, thirdRailResetOut, secondRailResetOut, mainRailResetOut};

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", nTests, failures);
      if (failures == 0 && nTests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   task automatic cmp_word(input string name, input logic [15:0] expV,
      input logic [15:0] seen);
      nTests++;
      if (seen !== expV)
      begin
         $display("ERROR %s expected %h seen %h", name, expV, seen);
         failures++;
      end
   endtask : cmp_word

   task automatic cmp_time(input string name, input int seen, input int lo,
      input int hi);
      nTests++;
      if (seen < lo || seen > hi)
      begin
         $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, seen);
         failures++;
      end
   endtask : cmp_time

   // Counts cycles until a watched output reaches val; gives up past hi + 20
   task automatic wait_level(input string name, input int idx,
      input logic val, input int lo, input int hi);
      int n;
      n = 0;
      while (obs[idx] !== val && n <= hi + 20)
      begin
         tick(1);
         n++;
      end
      if (n > hi + 20)
      begin
         $display("ERROR %s never reached, limit %0d", name, hi + 20);
         failures++;
         conclude();
      end
      else
         cmp_time(name, n, lo, hi);
   endtask : wait_level

   // offB is {D14, D9, D0}, dlyC is {D11, D10}, wdw is {D13, D12}
   function automatic logic [15:0] ctl(input logic [2:0] offB,
      input logic [5:0] trk, input logic [1:0] dlyC, input logic [1:0] wdw,
      input logic trig);
      return {trig, offB[2], wdw, dlyC, offB[1], 1'b1, trk, 1'b0, offB[0]};
   endfunction : ctl

   function automatic logic [15:0] exp_status();
      sswd_pkg::sswd_status_s s;
      s.wdFail = mWdFail[0];
      s.anyErr = overTemp | (|trackerShort) | s.wdFail;
      s.ramGood1 = mF1[0];
      s.ramGood2 = mF2[0];
      s.trkShort = trackerShort;
      s.trkOpen = trackerOpen;
      return s;
   endfunction : exp_status

   task automatic frame(input logic [15:0] w, input int nBits);
      logic [15:0] rd;
      logic [15:0] expSt;
      expQ.push_back(exp_status());
      sswd_host_model_inst.xfer(w, nBits, rd);
      tick(1);
      expSt = expQ.pop_front();
      if (nBits == 16)
      begin
         cmp_word("status", expSt, rd);
         mCtrl = w;
         mF1 = 0;
         mF2 = 0;
         mWdFail = 0;
      end
      cmp_word("trackers", 16'(mCtrl[7:2]), 16'(sensorTrackerEn));
      cmp_word("normal", 16'(mCtrl[8]), 16'(normalMode));
   endtask : frame

   initial
   begin
      rst_n = 1'b0;
      railGood = 3'h0;
      mainBelowRetain = 1'b0;
      secondBelowRetain = 1'b0;
      coldStart = 1'b1;
      overTemp = 1'b0;
      trackerShort = 6'h00;
      trackerOpen = 6'h00;
      mCtrl = ctl(3'h7, 6'h00, 2'h0, 2'h0, 1'b0);
      mF1 = 1;
      mF2 = 0;
      mWdFail = 0;
      tick(8);
      rst_n = 1'b1;
      tick(20);
      cmp_word("resets", 16'h0000, 16'(obs[2:0]));
      for (i = 0; i < 3; i++)
      begin
         railGood[i] = 1'b1;
         wait_level("release", i, 1'b1, dly[0], dly[0] + SLACK);
      end
      for (i = 0; i < 6; i++)
      begin
         rnd = $random(seed);
         trackerShort = i[0] ? rnd[5:0] : 6'h00;
         trackerOpen = rnd[11:6];
         overTemp = (i == 2);
         mainBelowRetain = rnd[12];
         secondBelowRetain = rnd[13];
         tick(10);
         mainBelowRetain = 1'b0;
         secondBelowRetain = 1'b0;
         mF1 = mF1 | rnd[12];
         mF2 = mF2 | rnd[13];
         tick(6);
         expB = ~(overTemp | (|trackerShort));
         cmp_word("errN", 16'(expB), 16'(errN));
         frame(ctl(3'h2, rnd[19:14], 2'h3, 2'h1, 1'b0), 16);
      end
      overTemp = 1'b0;
      trackerShort = 6'h00;
      mainBelowRetain = 1'b1;
      tick(10);
      mainBelowRetain = 1'b0;
      mF1 = 1;
      frame(ctl(3'h2, ~mCtrl[7:2], 2'h3, 2'h1, 1'b0), 15);
      frame(ctl(3'h2, 6'h15, 2'h3, 2'h1, 1'b0), 16);
      // Good triggers land mid open window, the status read mid closed one
      frame(ctl(3'h7, 6'h3F, 2'h3, 2'h1, 1'b0), 16);
      tick(330);
      frame(ctl(3'h7, 6'h3F, 2'h3, 2'h1, 1'b1), 16);
      tick(50);
      frame(ctl(3'h7, 6'h3F, 2'h3, 2'h1, 1'b0), 16);
      tick(130);
      frame(ctl(3'h7, 6'h3F, 2'h3, 2'h1, 1'b1), 16);
      cmp_word("errAndResets", 16'h000F, 16'(obs));
      tick(50);
      frame(ctl(3'h7, 6'h3F, 2'h3, 2'h1, 1'b1), 16);
      mWdFail = 1;
      cmp_word("errN", 16'h0000, 16'(errN));
      wait_level("failReset", 0, 1'b0, 150, 163);
      wait_level("failRelease", 0, 1'b1, dly[3] - 2, dly[3] + SLACK);
      frame(ctl(3'h2, 6'h3F, 2'h3, 2'h1, 1'b0), 16);
      cmp_word("errN", 16'h0001, 16'(errN));
      frame(ctl(3'h0, 6'h00, 2'h3, 2'h1, 1'b0), 16);
      wait_level("noTrigger", 3, 1'b0, 626, 644);
      wait_level("failReset", 0, 1'b0, 157, 163);
      wait_level("failRelease", 0, 1'b1, dly[3] - 2, dly[3] + SLACK);
      mWdFail = 1;
      coldStart = 1'b0;
      for (i = 0; i < 4; i++)
      begin
         rnd = $random(seed);
         frame(ctl(3'h2, rnd[5:0], i[1:0], 2'h1, 1'b0), 16);
         rst_n = 1'b0;
         tick(3);
         cmp_word("resets", 16'h0000, 16'(obs[2:0]));
         rst_n = 1'b1;
         mF1 = 0;
         mF2 = 0;
         mWdFail = 0;
         wait_level("warmRelease", 0, 1'b1, dly[i], dly[i] + SLACK);
         cmp_word("kept", 16'(mCtrl[7:2]), 16'(sensorTrackerEn));
      end
      coldStart = 1'b1;
      rst_n = 1'b0;
      tick(3);
      rst_n = 1'b1;
      mCtrl = ctl(3'h7, 6'h00, 2'h0, 2'h0, 1'b0);
      mF1 = 1;
      wait_level("coldRelease", 0, 1'b1, dly[0], dly[0] + SLACK);
      cmp_word("cold", 16'h0000, 16'(sensorTrackerEn));
      frame(ctl(3'h2, 6'h00, 2'h0, 2'h0, 1'b0), 16);
      cmp_word("doDrive", 16'h0000, 16'(sswd_host_model_inst.oeLost));
      conclude();
   end
endmodule : tb_top
`default_nettype wire
